//--- verilog/ifsl_pkg.sv
// Package for the low interrupt flag group: register map, field layout,
// reset values and limit widths.
// Assumes a plain strobe register port on one 50 MHz clock.
package ifsl_pkg;

    // Register word addresses
    localparam logic [3:0] IFSL_ADDR_FLAGS      = 4'h0;  // Sticky status, write one to clear
    localparam logic [3:0] IFSL_ADDR_MASK       = 4'h1;  // Interrupt enable mask
    localparam logic [3:0] IFSL_ADDR_LOWER      = 4'h2;  // lower_limit
    localparam logic [3:0] IFSL_ADDR_UPPER      = 4'h3;  // upper_limit
    localparam logic [3:0] IFSL_ADDR_STEP       = 4'h4;  // step_limit
    localparam logic [3:0] IFSL_ADDR_LAST       = 4'h5;  // Last ADC sample, read only
    localparam logic [3:0] IFSL_ADDR_CHECK      = 4'h6;  // Limit check enable bits

    // Flag positions
    localparam int IFSL_BIT_ADC      = 0;
    localparam int IFSL_BIT_XFORM    = 1;
    localparam int IFSL_BIT_FILTER   = 2;
    localparam int IFSL_BIT_TEMP     = 3;
    localparam int IFSL_BIT_BELOW    = 4;
    localparam int IFSL_BIT_ABOVE    = 5;
    localparam int IFSL_BIT_STEP     = 6;
    localparam int IFSL_BIT_AVERAGE  = 7;
    localparam int IFSL_BIT_SPREAD   = 8;
    localparam int IFSL_BIT_USER0    = 9;
    localparam int IFSL_NUM_FLAGS    = 12;

    // Check enable bit positions
    localparam int IFSL_CHK_MIN      = 0;
    localparam int IFSL_CHK_MAX      = 1;
    localparam int IFSL_CHK_STEP     = 2;

    localparam int IFSL_DATA_W       = 16;
    localparam int IFSL_BUS_W        = 32;

    // Reset values
    localparam logic [11:0] IFSL_FLAGS_RST = 12'h000;
    localparam logic [11:0] IFSL_MASK_RST  = 12'h000;
    localparam logic [15:0] IFSL_LOWER_RST = 16'h0000;
    localparam logic [15:0] IFSL_UPPER_RST = 16'hFFFF;
    localparam logic [15:0] IFSL_STEP_RST  = 16'hFFFF;
    localparam logic [2:0]  IFSL_CHECK_RST = 3'h0;

endpackage : ifsl_pkg

//--- verilog/ifsl_chk_if.sv
// Interface carrying limit-check verdicts from the checker to the flag core.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
interface ifsl_chk_if;
    logic below;   // Sample below lower limit
    logic above;   // Sample above upper limit
    logic step;    // Step to previous sample over limit
    modport src (output below, output above, output step);
    modport dst (input below, input above, input step);
endinterface : ifsl_chk_if

//--- verilog/ifsl_limit_chk.sv
// ADC limit checker: compares each new sample against the lower, upper and
// step limits. Assumes samples arrive as one-cycle valid pulses on sys_clk.
`timescale 1ns/1ps
module ifsl_limit_chk
    import ifsl_pkg::*;
#(
    parameter int W = IFSL_DATA_W
)(
    // Clock and reset
    input  wire logic           sys_clk,
    input  wire logic           sys_rst,
    // Sample stream
    input  wire logic           sample_valid,
    input  wire logic [W-1:0]   sample,
    // Limits and enables
    input  wire logic [W-1:0]   lower_limit,
    input  wire logic [W-1:0]   upper_limit,
    input  wire logic [W-1:0]   step_limit,
    input  wire logic [2:0]     check_en,
    // Verdicts and history
    output logic     [W-1:0]    last_sample,
    ifsl_chk_if.src             chk
);

    logic have_last;   // No step exists before the first sample

    // Absolute difference, unsigned samples
    function automatic logic [W-1:0] abs_diff(input logic [W-1:0] a, input logic [W-1:0] b);
        abs_diff = (a >= b) ? (a - b) : (b - a);
    endfunction : abs_diff

    // Remember previous sample for the step check
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            last_sample <= '0;
            have_last   <= 1'b0;
        end
        else if (sample_valid)
        begin
            last_sample <= sample;
            have_last   <= 1'b1;
        end
    end

    // Verdicts are one-cycle pulses alongside the sample
    assign chk.below = sample_valid && check_en[IFSL_CHK_MIN] && (sample < lower_limit);
    assign chk.above = sample_valid && check_en[IFSL_CHK_MAX] && (sample > upper_limit);
    assign chk.step  = sample_valid && check_en[IFSL_CHK_STEP] && have_last
                       && (abs_diff(sample, last_sample) > step_limit);

endmodule : ifsl_limit_chk

//--- verilog/ifsl_flags.sv
// Low interrupt flag group: sticky event flags, mask, interrupt output and
// the software register port. Assumes event inputs are one-cycle pulses
// from logic on sys_clk; the register master never issues both strobes.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

// Overview of operation
// - Set step flag when two successive samples differ by more than step limit.
// - Step flag stays set until software clears it.
// - Set upper flag when a sample exceeds the upper limit.
// - Set lower flag when a sample falls below the lower limit.
// - Lower flag stays set until cleared.
// - Three user event flags, read only, reset to zero.
// - Temperature done flag, read only, resets to zero.
// - Filter ready flag reads one when second stage filter has a result.
// - Transform done flag reads one when the transform engine finishes.
// - ADC result flag reads one on a new conversion, resets to zero.
module ifsl_flags
    import ifsl_pkg::*;
#(
    parameter int W = IFSL_DATA_W
)(
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    // Event sources
    input  wire logic                   adc_valid,
    input  wire logic [W-1:0]           adc_data,
    input  wire logic                   transform_done,
    input  wire logic                   filter_ready,
    input  wire logic                   temperature_done,
    input  wire logic                   average_done,
    input  wire logic                   spread_done,
    input  wire logic [2:0]             seq_user_event,
    // Register port
    input  wire logic [3:0]             reg_addr,
    input  wire logic [IFSL_BUS_W-1:0]  reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [IFSL_BUS_W-1:0]  reg_rdata,
    // Interrupt
    output logic                        irq
);

    logic [IFSL_NUM_FLAGS-1:0] flags;
    logic [IFSL_NUM_FLAGS-1:0] mask;
    logic [IFSL_NUM_FLAGS-1:0] events;
    logic [IFSL_NUM_FLAGS-1:0] clr;
    logic [IFSL_NUM_FLAGS-1:0] next_flags;
    logic [W-1:0]              lower_limit;
    logic [W-1:0]              upper_limit;
    logic [W-1:0]              step_limit;
    logic [W-1:0]              last_sample;
    logic [2:0]                check_en;
    logic [IFSL_BUS_W-1:0]     next_rdata;

    // Named sticky flags, gathered into the status layout below
    logic                      adc_result_flag;
    logic                      transform_done_flag;
    logic                      filter_ready_flag;
    logic                      temperature_done_flag;
    logic                      below_min_flag;
    logic                      above_max_flag;
    logic                      step_too_large_flag;
    logic                      average_done_flag;
    logic                      spread_done_flag;
    logic                      user_event0_flag;
    logic                      user_event1_flag;
    logic                      user_event2_flag;

    ifsl_chk_if chk ();

    // Register decode, shared by the clear path and every writable register
    // One compare function keeps the write and clear decodes from drifting apart
    function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] target);
        addr_hit = (addr == target);
    endfunction : addr_hit

    // Limit comparisons on every new ADC sample
    ifsl_limit_chk #(
        .W            (W)
    ) u_chk (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .sample_valid (adc_valid),
        .sample       (adc_data),
        .lower_limit  (lower_limit),
        .upper_limit  (upper_limit),
        .step_limit   (step_limit),
        .check_en     (check_en),
        .last_sample  (last_sample),
        .chk          (chk)
    );

    // Gather event pulses into flag layout
    always_comb
    begin
        events                       = '0;
        events[IFSL_BIT_ADC]         = adc_valid;
        events[IFSL_BIT_XFORM]       = transform_done;
        events[IFSL_BIT_FILTER]      = filter_ready;
        events[IFSL_BIT_TEMP]        = temperature_done;
        events[IFSL_BIT_BELOW]       = chk.below;
        events[IFSL_BIT_ABOVE]       = chk.above;
        events[IFSL_BIT_STEP]        = chk.step;
        events[IFSL_BIT_AVERAGE]     = average_done;
        events[IFSL_BIT_SPREAD]      = spread_done;
        // Only the sequencer drives these; host writes cannot raise them
        events[IFSL_BIT_USER0 +: 3]  = seq_user_event;
    end

    // Write one to clear the status register
    assign clr = (reg_wr && addr_hit(reg_addr, IFSL_ADDR_FLAGS))
                 ? reg_wdata[IFSL_NUM_FLAGS-1:0] : '0;

    // Set wins over a clear in the same cycle so no event is lost
    assign next_flags = (flags & ~clr) | events;

    // Sticky flags, one process per flag so each source can be traced alone;
    // all of them follow next_flags, so a set still wins over a clear

    // ADC result: a new conversion result is available
    // Held until cleared, so a slow reader cannot miss a result
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            adc_result_flag <= IFSL_FLAGS_RST[IFSL_BIT_ADC];
        else
            adc_result_flag <= next_flags[IFSL_BIT_ADC];
    end

    // Transform engine finished a result
    // Source is a one-cycle pulse; the flag stretches it for software
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            transform_done_flag <= IFSL_FLAGS_RST[IFSL_BIT_XFORM];
        else
            transform_done_flag <= next_flags[IFSL_BIT_XFORM];
    end

    // Second stage filter has a new result ready
    // Same pulse stretching as the transform flag
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            filter_ready_flag <= IFSL_FLAGS_RST[IFSL_BIT_FILTER];
        else
            filter_ready_flag <= next_flags[IFSL_BIT_FILTER];
    end

    // Temperature conversion result is available
    // Resets low so a stale result never shows after reset
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            temperature_done_flag <= IFSL_FLAGS_RST[IFSL_BIT_TEMP];
        else
            temperature_done_flag <= next_flags[IFSL_BIT_TEMP];
    end

    // A sample fell below the lower limit
    // Stays set across later in-range samples until software clears it
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            below_min_flag <= IFSL_FLAGS_RST[IFSL_BIT_BELOW];
        else
            below_min_flag <= next_flags[IFSL_BIT_BELOW];
    end

    // A sample rose above the upper limit
    // Equal to the limit is still in range
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            above_max_flag <= IFSL_FLAGS_RST[IFSL_BIT_ABOVE];
        else
            above_max_flag <= next_flags[IFSL_BIT_ABOVE];
    end

    // Two successive samples differed by more than the step limit
    // Stays set until cleared, even if later steps are small
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            step_too_large_flag <= IFSL_FLAGS_RST[IFSL_BIT_STEP];
        else
            step_too_large_flag <= next_flags[IFSL_BIT_STEP];
    end

    // Mean statistic finished
    // Kept sticky like the others so one clear rule covers the group
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            average_done_flag <= IFSL_FLAGS_RST[IFSL_BIT_AVERAGE];
        else
            average_done_flag <= next_flags[IFSL_BIT_AVERAGE];
    end

    // Variance statistic finished
    // Kept sticky like the others so one clear rule covers the group
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            spread_done_flag <= IFSL_FLAGS_RST[IFSL_BIT_SPREAD];
        else
            spread_done_flag <= next_flags[IFSL_BIT_SPREAD];
    end

    // Sequencer user event zero
    // Only the sequencer pulse sets it; host writes can only clear it
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            user_event0_flag <= IFSL_FLAGS_RST[IFSL_BIT_USER0];
        else
            user_event0_flag <= next_flags[IFSL_BIT_USER0];
    end

    // Sequencer user event one
    // Only the sequencer pulse sets it; host writes can only clear it
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            user_event1_flag <= IFSL_FLAGS_RST[IFSL_BIT_USER0 + 1];
        else
            user_event1_flag <= next_flags[IFSL_BIT_USER0 + 1];
    end

    // Sequencer user event two
    // Only the sequencer pulse sets it; host writes can only clear it
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            user_event2_flag <= IFSL_FLAGS_RST[IFSL_BIT_USER0 + 2];
        else
            user_event2_flag <= next_flags[IFSL_BIT_USER0 + 2];
    end

    // Status word in the bit layout that software sees
    always_comb
    begin
        flags                        = '0;
        flags[IFSL_BIT_ADC]          = adc_result_flag;
        flags[IFSL_BIT_XFORM]        = transform_done_flag;
        flags[IFSL_BIT_FILTER]       = filter_ready_flag;
        flags[IFSL_BIT_TEMP]         = temperature_done_flag;
        flags[IFSL_BIT_BELOW]        = below_min_flag;
        flags[IFSL_BIT_ABOVE]        = above_max_flag;
        flags[IFSL_BIT_STEP]         = step_too_large_flag;
        flags[IFSL_BIT_AVERAGE]      = average_done_flag;
        flags[IFSL_BIT_SPREAD]       = spread_done_flag;
        flags[IFSL_BIT_USER0]        = user_event0_flag;
        flags[IFSL_BIT_USER0 + 1]    = user_event1_flag;
        flags[IFSL_BIT_USER0 + 2]    = user_event2_flag;
    end

    // Interrupt mask; a masked flag still latches, it only stays off irq
    // Masking never loses an event, so unmasking later raises irq on the edge after the mask loads
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            mask <= IFSL_MASK_RST;
        else if (reg_wr && addr_hit(reg_addr, IFSL_ADDR_MASK))
            mask <= reg_wdata[IFSL_NUM_FLAGS-1:0];
    end

    // Lower limit for the below-range check
    // Takes effect from the next sample; no sample is checked twice
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            lower_limit <= IFSL_LOWER_RST;
        else if (reg_wr && addr_hit(reg_addr, IFSL_ADDR_LOWER))
            lower_limit <= reg_wdata[W-1:0];
    end

    // Upper limit for the above-range check
    // Reset value is full scale, so nothing trips before it is written
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            upper_limit <= IFSL_UPPER_RST;
        else if (reg_wr && addr_hit(reg_addr, IFSL_ADDR_UPPER))
            upper_limit <= reg_wdata[W-1:0];
    end

    // Largest allowed difference between successive samples
    // Reset value is full scale, so no step can exceed it
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            step_limit <= IFSL_STEP_RST;
        else if (reg_wr && addr_hit(reg_addr, IFSL_ADDR_STEP))
            step_limit <= reg_wdata[W-1:0];
    end

    // Enables of the three limit checks; all off after reset
    // Writes to the status, last-sample or unmapped words touch none of these
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            check_en <= IFSL_CHECK_RST;
        else if (reg_wr && addr_hit(reg_addr, IFSL_ADDR_CHECK))
            check_en <= reg_wdata[2:0];
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        next_rdata = '0;
        unique case (reg_addr)
            IFSL_ADDR_FLAGS: next_rdata[IFSL_NUM_FLAGS-1:0] = flags;
            IFSL_ADDR_MASK:  next_rdata[IFSL_NUM_FLAGS-1:0] = mask;
            IFSL_ADDR_LOWER: next_rdata[W-1:0]              = lower_limit;
            IFSL_ADDR_UPPER: next_rdata[W-1:0]              = upper_limit;
            IFSL_ADDR_STEP:  next_rdata[W-1:0]              = step_limit;
            IFSL_ADDR_LAST:  next_rdata[W-1:0]              = last_sample;
            IFSL_ADDR_CHECK: next_rdata[2:0]                = check_en;
            default:         next_rdata                     = '0;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= '0;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= '0;
    end

    // Level interrupt from next_flags, registered so it changes on the same edge as the flags
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= |(next_flags & mask);
    end

endmodule : ifsl_flags

//--- testbench/ifsl_flags_checker.sv
// Checker for the low interrupt flag group, bound onto ifsl_flags.
// Assumes the register map and flag layout of ifsl_pkg on one clock.
`timescale 1ns/1ps
module ifsl_flags_checker
    import ifsl_pkg::*;
#(
    parameter int W = IFSL_DATA_W
)(
    // Clock, reset and event sources
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  adc_valid,
    input  wire logic                  transform_done,
    // Register port and interrupt
    input  wire logic [3:0]            reg_addr,
    input  wire logic [IFSL_BUS_W-1:0] reg_wdata,
    input  wire logic [IFSL_BUS_W-1:0] reg_rdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic                  irq
);
    // Shadow of the mask, so irq can be judged from port traffic alone
    logic [11:0] msk;
    logic        st_rd;
    assign st_rd = reg_rd && reg_addr == IFSL_ADDR_FLAGS;
    always_ff @(posedge sys_clk or posedge sys_rst)
        if (sys_rst)
            msk <= IFSL_MASK_RST;
        else if (reg_wr && reg_addr == IFSL_ADDR_MASK)
            msk <= reg_wdata[11:0];

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // A read in the cycle after an event shows it; a flag read set stays set
    property seen(ev, b); ev ##1 st_rd |=> reg_rdata[b]; endproperty
    property stays(b); st_rd ##1 (st_rd && reg_rdata[b]) |=> reg_rdata[b]; endproperty

    adc_seen_a: assert property (seen(adc_valid, IFSL_BIT_ADC))
        else $error("adc result flag not set");
    xform_seen_a: assert property (seen(transform_done, IFSL_BIT_XFORM))
        else $error("transform flag not set");
    step_stays_a: assert property (stays(IFSL_BIT_STEP))
        else $error("step flag dropped without a clear");
    below_stays_a: assert property (stays(IFSL_BIT_BELOW))
        else $error("below flag dropped without a clear");
    clear_works_a: assert property (reg_wr && reg_addr == IFSL_ADDR_FLAGS
        && reg_wdata[IFSL_BIT_XFORM] && !transform_done ##1 (st_rd && !transform_done)
        |=> !reg_rdata[IFSL_BIT_XFORM]) else $error("transform flag survived a clear");
    irq_mask_a: assert property (irq |-> $past(msk) != 12'h000)
        else $error("irq high with every source masked");
    irq_raise_a: assert property (transform_done && msk[IFSL_BIT_XFORM] |=> irq)
        else $error("irq missed an unmasked event");
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data outside a read reply");
    unmapped_zero_a: assert property (reg_rd && reg_addr > IFSL_ADDR_CHECK |=> reg_rdata == '0)
        else $error("unmapped read not zero");

    cover property (st_rd ##1 st_rd ##1 st_rd);
    cover property ($rose(irq));
    cover property (transform_done && reg_wr && reg_addr == IFSL_ADDR_FLAGS);
endmodule : ifsl_flags_checker

bind ifsl_flags ifsl_flags_checker #(.W(W)) u_checker (.*);

//--- testbench/ifsl_flags_tb_top.sv
// Testbench for ifsl_flags: reset reads, a table of event rows, then sticky,
// interrupt, clear-collision and checks-off cases. Assumes the checker binds itself.
`timescale 1ns/1ps
module ifsl_flags_tb_top
    import ifsl_pkg::*;
;
    typedef struct packed {logic [8:0] e; logic [15:0] d; logic [11:0] x;} ifsl_row_t;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, adc_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        irq;
    logic [7:0]  ev = '0;
    logic [3:0]  reg_addr = '0;
    logic [15:0] adc_data = '0;
    logic [31:0] reg_wdata = '0, reg_rdata;
    int          errors = 0, n_compared = 0, cycles = 0;
    // e: 8 ADC valid, 4:0 transform, filter, temperature, average, spread, 7:5 user.
    // Limits 0x0100..0x0200, step 0x0050; the first sample has no step check.
    ifsl_row_t rows [16] = '{
        '{9'h001, 16'h0, 12'h002}, '{9'h002, 16'h0, 12'h004}, '{9'h004, 16'h0, 12'h008},
        '{9'h008, 16'h0, 12'h080}, '{9'h010, 16'h0, 12'h100}, '{9'h020, 16'h0, 12'h200},
        '{9'h040, 16'h0, 12'h400}, '{9'h080, 16'h0, 12'h800}, '{9'h100, 16'h0150, 12'h001},
        '{9'h100, 16'h0190, 12'h001}, '{9'h100, 16'h01E0, 12'h001}, '{9'h100, 16'h0231, 12'h061},
        '{9'h100, 16'h0200, 12'h001}, '{9'h100, 16'h0100, 12'h041}, '{9'h100, 16'h00FF, 12'h011},
        '{9'h1FF, 16'h0050, 12'hFDF}};

    ifsl_flags DUT (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .adc_valid(adc_valid), .adc_data(adc_data),
        .transform_done(ev[0]), .filter_ready(ev[1]), .temperature_done(ev[2]),
        .average_done(ev[3]), .spread_done(ev[4]), .seq_user_event(ev[7:5]),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));

    // 50 MHz system clock
    always #10 sys_clk = ~sys_clk;

    // Hang guard; the tests need about 140 cycles
    always @(posedge sys_clk)
        if (++cycles == 3000)
        begin
            errors++;
            summarize();
        end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe, so sample at that edge
    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        chk(reg_rdata, exp);
    endtask : rdchk

    task automatic summarize();
        if (errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rdchk(IFSL_ADDR_FLAGS, 32'h0);
        rdchk(IFSL_ADDR_UPPER, 32'h0000_FFFF);
        rdchk(4'hF, 32'h0);
        wr(IFSL_ADDR_LOWER, 32'h0000_0100);
        wr(IFSL_ADDR_UPPER, 32'h0000_0200);
        wr(IFSL_ADDR_STEP, 32'h0000_0050);
        wr(IFSL_ADDR_CHECK, 32'h0000_0007);
        // Each row: pulse, read, clear with all ones, read back zero
        foreach (rows[i])
        begin
            {adc_valid, ev, adc_data} <= {rows[i].e, rows[i].d};
            @(posedge sys_clk);
            {adc_valid, ev} <= '0;
            rdchk(IFSL_ADDR_FLAGS, {20'h0, rows[i].x});
            wr(IFSL_ADDR_FLAGS, 32'h0000_0FFF);
            rdchk(IFSL_ADDR_FLAGS, 32'h0);
        end
        // Step and below trip on one sample, then three reads back to back
        {adc_valid, adc_data} <= {1'b1, 16'h00F0};
        @(posedge sys_clk);
        {adc_valid, reg_addr, reg_rd} <= {1'b0, IFSL_ADDR_FLAGS, 1'b1};
        repeat (3) @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        chk(reg_rdata, 32'h0000_0051);
        chk({31'h0, irq}, 32'h0);
        rdchk(IFSL_ADDR_LAST, 32'h0000_00F0);
        // irq is registered, so it trails a mask write by two edges and a clear by one
        wr(IFSL_ADDR_MASK, 32'h0000_0012);
        rdchk(IFSL_ADDR_MASK, 32'h0000_0012);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        wr(IFSL_ADDR_FLAGS, 32'h0000_0050);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        // A clear colliding with a fresh event must leave the flag set
        ev <= 8'h01;
        wr(IFSL_ADDR_FLAGS, 32'h0000_0002);
        ev <= '0;
        rdchk(IFSL_ADDR_FLAGS, 32'h0000_0003);
        chk({31'h0, irq}, 32'h1);
        // With the checks off an out-of-range sample sets only the ADC flag
        wr(IFSL_ADDR_FLAGS, 32'h0000_0FFF);
        wr(IFSL_ADDR_CHECK, 32'h0000_0000);
        {adc_valid, adc_data} <= {1'b1, 16'h0300};
        @(posedge sys_clk);
        adc_valid <= 1'b0;
        rdchk(IFSL_ADDR_FLAGS, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0);
        summarize();
    end
endmodule : ifsl_flags_tb_top
